// ==== logic/flash_susp_pkg.sv ====
/*
 * Constants and types for the suspend/resume sequencer of the serial flash.
 * Assumes a 20 MHz system clock; the host serial clock is a separate domain.
 */
package flash_susp_pkg;

    // system clock
    localparam int CLK_PERIOD_NS = 50;

    // single-byte opcodes shared by erase and program
    localparam logic [7:0] OPC_SUSPEND = 8'h75;
    localparam logic [7:0] OPC_RESUME  = 8'h7A;
    localparam int         OPCODE_BITS = 8;
    localparam int         BIT_CNT_W   = 4;

    // advertised capability: zero means suspend/resume supported
    localparam logic CAP_SUSPEND_SUPPORTED = 1'h0;

    // suspend latency fields: unit code 01b is 1 us, count 10011b
    localparam logic [1:0] LAT_UNIT_CODE  = 2'h1;
    localparam int         LAT_UNIT_NS    = 1000;
    localparam logic [4:0] ERASE_LAT_CNT  = 5'h13;
    localparam logic [4:0] PROG_LAT_CNT   = 5'h13;
    localparam int ERASE_SUSP_LAT_NS = (int'(ERASE_LAT_CNT) + 1) * LAT_UNIT_NS;
    localparam int PROG_SUSP_LAT_NS  = (int'(PROG_LAT_CNT) + 1) * LAT_UNIT_NS;
    // longest times round down
    localparam int ERASE_SUSP_LAT_CYC = ERASE_SUSP_LAT_NS / CLK_PERIOD_NS;
    localparam int PROG_SUSP_LAT_CYC  = PROG_SUSP_LAT_NS / CLK_PERIOD_NS;

    // resume-to-suspend interval: count 0001b plus one, times 64 us
    localparam logic [3:0] RESUME_INT_CNT  = 4'h1;
    localparam int         RESUME_UNIT_NS  = 64000;
    localparam int RESUME_INT_NS  = (int'(RESUME_INT_CNT) + 1) * RESUME_UNIT_NS;
    // least time rounds up
    localparam int RESUME_INT_CYC = (RESUME_INT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // prohibited-operation fields (erase suspend, program suspend)
    localparam logic [3:0] PROHIBIT_ERASE_SUSP = 4'hC;
    localparam logic [3:0] PROHIBIT_PROG_SUSP  = 4'hC;

    localparam int CNT_W = 12;

    typedef enum logic [6:0] {
        ST_IDLE       = 7'h01,
        ST_ERASING    = 7'h02,
        ST_ERASE_PEND = 7'h04,
        ST_ERASE_SUSP = 7'h08,
        ST_PROGRAMING = 7'h10,
        ST_PROG_PEND  = 7'h20,
        ST_PROG_SUSP  = 7'h40
    } seq_state_t;

endpackage

// ==== logic/flash_suspend_seq.sv ====
/*
 * Suspend/resume sequencer for erase and page program of a serial flash.
 * Assumes an erase/program engine on clk that starts on a one-cycle pulse,
 * pulses done when finished and reports when it has parked under hold.
 * The host serial link (sck, csN, mosi) is asynchronous to clk.
 */
// Overview of operation
// - device supports suspend and resume, advertising a zero capability bit.
// - erase reaches suspended state within twenty 1 us units of suspend.
// - page program reaches suspended state within twenty 1 us units.
// - opcode 75h during an erase suspends that erase.
// - opcode 7Ah while erase is suspended resumes the erase.
// - opcode 75h during a page program suspends the program.
// - opcode 7Ah while program is suspended resumes the program.
`timescale 1ns/1ns
`default_nettype none

module flash_suspend_seq (
    // system
    input  wire logic clk,
    input  wire logic reset,
    // host serial link
    input  wire logic sck,
    input  wire logic csN,
    input  wire logic mosi,
    // engine requests and status
    input  wire logic eraseStart,
    input  wire logic programStart,
    input  wire logic engineDone,
    input  wire logic engineParked,
    // sequencer status
    output logic      engineHold,
    output logic      eraseActive,
    output logic      programActive,
    output logic      eraseSuspended,
    output logic      programSuspended,
    output logic      suspendTooSoon,
    output logic      suspendCapBit
);

    localparam int ERASE_BOUND = flash_susp_pkg::ERASE_SUSP_LAT_CYC;
    localparam int PROG_BOUND  = flash_susp_pkg::PROG_SUSP_LAT_CYC;

    typedef struct packed {
        flash_susp_pkg::seq_state_t         st;
        logic                               syncA;
        logic                               syncB;
        logic                               seen;
        logic [flash_susp_pkg::CNT_W-1:0]   latCnt;
        logic [flash_susp_pkg::CNT_W-1:0]   guard;
        logic                               hold;
        logic                               eraseAct;
        logic                               progAct;
        logic                               eraseSusp;
        logic                               progSusp;
        logic                               tooSoon;
        logic                               cap;
    } regs_t;

    regs_t      s;
    regs_t      next_s;
    logic [7:0] linkOpcode;
    logic       linkToggle;
    logic       cmdEvent;
    logic       isSuspend;
    logic       isResume;

    spi_opcode_capture u_capture (
        .sck        (sck),
        .csN        (csN),
        .mosi       (mosi),
        .reset      (reset),
        .opcode     (linkOpcode),
        .byteToggle (linkToggle)
    );

    // the opcode is held for at least eight serial clocks after the toggle
    assign cmdEvent  = s.syncB ^ s.seen;
    assign isSuspend = cmdEvent && (linkOpcode == flash_susp_pkg::OPC_SUSPEND);
    assign isResume  = cmdEvent && (linkOpcode == flash_susp_pkg::OPC_RESUME);

    always_comb begin
        next_s         = s;
        next_s.syncA   = linkToggle;
        next_s.syncB   = s.syncA;
        next_s.seen    = s.syncB;
        next_s.tooSoon = 1'h0;
        next_s.cap     = flash_susp_pkg::CAP_SUSPEND_SUPPORTED;
        if (s.guard != '0) begin
            next_s.guard = s.guard - 12'h001;
        end
        case (s.st)
            flash_susp_pkg::ST_IDLE: begin
                // suspend and resume opcodes fall through unused
                // a finished operation leaves no resume interval for the next one
                next_s.guard = '0;
                if (eraseStart) begin
                    next_s.st = flash_susp_pkg::ST_ERASING;
                end else if (programStart) begin
                    next_s.st = flash_susp_pkg::ST_PROGRAMING;
                end
            end
            flash_susp_pkg::ST_ERASING: begin
                if (engineDone) begin
                    next_s.st = flash_susp_pkg::ST_IDLE;
                end else if (isSuspend) begin
                    if (s.guard != '0) begin
                        next_s.tooSoon = 1'h1;
                    end else begin
                        next_s.st     = flash_susp_pkg::ST_ERASE_PEND;
                        next_s.latCnt = '0;
                    end
                end
            end
            flash_susp_pkg::ST_ERASE_PEND: begin
                next_s.latCnt = s.latCnt + 12'h001;
                if (engineDone) begin
                    next_s.st = flash_susp_pkg::ST_IDLE;
                end else if (engineParked || s.latCnt ==
                             flash_susp_pkg::CNT_W'(ERASE_BOUND - 2)) begin
                    next_s.st = flash_susp_pkg::ST_ERASE_SUSP;
                end
            end
            flash_susp_pkg::ST_ERASE_SUSP: begin
                // new erase or program starts are dropped here
                if (isResume) begin
                    next_s.st    = flash_susp_pkg::ST_ERASING;
                    next_s.guard = flash_susp_pkg::CNT_W'(flash_susp_pkg::RESUME_INT_CYC);
                end
            end
            flash_susp_pkg::ST_PROGRAMING: begin
                if (engineDone) begin
                    next_s.st = flash_susp_pkg::ST_IDLE;
                end else if (isSuspend) begin
                    if (s.guard != '0) begin
                        next_s.tooSoon = 1'h1;
                    end else begin
                        next_s.st     = flash_susp_pkg::ST_PROG_PEND;
                        next_s.latCnt = '0;
                    end
                end
            end
            flash_susp_pkg::ST_PROG_PEND: begin
                next_s.latCnt = s.latCnt + 12'h001;
                if (engineDone) begin
                    next_s.st = flash_susp_pkg::ST_IDLE;
                end else if (engineParked || s.latCnt ==
                             flash_susp_pkg::CNT_W'(PROG_BOUND - 2)) begin
                    next_s.st = flash_susp_pkg::ST_PROG_SUSP;
                end
            end
            flash_susp_pkg::ST_PROG_SUSP: begin
                // erase and program starts are dropped here
                if (isResume) begin
                    next_s.st    = flash_susp_pkg::ST_PROGRAMING;
                    next_s.guard = flash_susp_pkg::CNT_W'(flash_susp_pkg::RESUME_INT_CYC);
                end
            end
            default: begin
                next_s.st = flash_susp_pkg::ST_IDLE;
            end
        endcase
        next_s.eraseAct  = (next_s.st == flash_susp_pkg::ST_ERASING);
        next_s.progAct   = (next_s.st == flash_susp_pkg::ST_PROGRAMING);
        next_s.eraseSusp = (next_s.st == flash_susp_pkg::ST_ERASE_SUSP);
        next_s.progSusp  = (next_s.st == flash_susp_pkg::ST_PROG_SUSP);
        next_s.hold      = (next_s.st == flash_susp_pkg::ST_ERASE_PEND) ||
                           (next_s.st == flash_susp_pkg::ST_ERASE_SUSP) ||
                           (next_s.st == flash_susp_pkg::ST_PROG_PEND)  ||
                           (next_s.st == flash_susp_pkg::ST_PROG_SUSP);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s     <= '0;
            s.st  <= flash_susp_pkg::ST_IDLE;
            s.cap <= flash_susp_pkg::CAP_SUSPEND_SUPPORTED;
        end else begin
            s <= next_s;
        end
    end

    assign engineHold       = s.hold;
    assign eraseActive      = s.eraseAct;
    assign programActive    = s.progAct;
    assign eraseSuspended   = s.eraseSusp;
    assign programSuspended = s.progSusp;
    assign suspendTooSoon   = s.tooSoon;
    assign suspendCapBit    = s.cap;

    AST_CAP_ZERO: assert property (@(posedge clk) disable iff (reset)
        ##1 (suspendCapBit == 1'h0)) else $error("capability bit not zero");

    AST_ERASE_LATENCY: assert property (@(posedge clk) disable iff (reset)
        (eraseActive && isSuspend && s.guard == '0 && !engineDone)
        |-> ##[1:ERASE_BOUND] (eraseSuspended || !engineHold))
        else $error("erase suspend latency exceeded");

    AST_PROG_LATENCY: assert property (@(posedge clk) disable iff (reset)
        (programActive && isSuspend && s.guard == '0 && !engineDone)
        |-> ##[1:PROG_BOUND] (programSuspended || !engineHold))
        else $error("program suspend latency exceeded");

    AST_ERASE_SUSPEND: assert property (@(posedge clk) disable iff (reset)
        (s.st == flash_susp_pkg::ST_ERASING && isSuspend && s.guard == '0 && !engineDone)
        |=> (engineHold && !eraseActive)) else $error("erase suspend not taken");

    AST_ERASE_RESUME: assert property (@(posedge clk) disable iff (reset)
        (eraseSuspended && isResume)
        |=> (eraseActive && !engineHold && s.guard ==
             flash_susp_pkg::CNT_W'(flash_susp_pkg::RESUME_INT_CYC)))
        else $error("erase resume not taken");

    AST_PROG_SUSPEND: assert property (@(posedge clk) disable iff (reset)
        (s.st == flash_susp_pkg::ST_PROGRAMING && isSuspend && s.guard == '0 && !engineDone)
        |=> (engineHold && !programActive)) else $error("program suspend not taken");

    AST_PROG_RESUME: assert property (@(posedge clk) disable iff (reset)
        (programSuspended && isResume) |=> (programActive && !engineHold))
        else $error("program resume not taken");

    AST_IGNORE_IDLE: assert property (@(posedge clk) disable iff (reset)
        (s.st == flash_susp_pkg::ST_IDLE && cmdEvent && !eraseStart && !programStart)
        |=> $stable(s.st)) else $error("idle state moved on stray opcode");

    AST_ERASE_SUSP_STARTS: assert property (@(posedge clk) disable iff (reset)
        (eraseSuspended && (eraseStart || programStart) && !isResume)
        |=> eraseSuspended) else $error("start accepted during erase suspend");

    AST_PROG_SUSP_STARTS: assert property (@(posedge clk) disable iff (reset)
        (programSuspended && (eraseStart || programStart) && !isResume)
        |=> programSuspended) else $error("start accepted during program suspend");

endmodule

`default_nettype wire

// ==== logic/spi_opcode_capture.sv ====
/*
 * Serial-clock side: shifts in the first byte of each frame and flags it
 * with a toggle. Assumes mode 0/3 sampling on the rising serial clock edge
 * and a serial clock that stands still while the chip select is high.
 */
`timescale 1ns/1ns
`default_nettype none

module spi_opcode_capture (
    // link pins
    input  wire logic       sck,
    input  wire logic       csN,
    input  wire logic       mosi,
    // system reset, used only to give the toggle and the captured opcode a known start
    input  wire logic       reset,
    // captured byte and its event toggle
    output logic [7:0]      opcode,
    output logic            byteToggle
);

    typedef struct packed {
        logic [flash_susp_pkg::BIT_CNT_W-1:0] cnt;
        logic [6:0]                           shift;
    } shift_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic       toggle;
    } cap_t;

    shift_t sh;
    shift_t next_sh;
    cap_t   cap;
    cap_t   next_cap;

    always_comb begin
        next_sh  = sh;
        next_cap = cap;
        if (sh.cnt < flash_susp_pkg::BIT_CNT_W'(flash_susp_pkg::OPCODE_BITS)) begin
            next_sh.shift = {sh.shift[5:0], mosi};
            next_sh.cnt   = sh.cnt + 4'h1;
        end
        if (sh.cnt == flash_susp_pkg::BIT_CNT_W'(flash_susp_pkg::OPCODE_BITS - 1)) begin
            next_cap.opcode = {sh.shift, mosi};
            next_cap.toggle = ~cap.toggle;
        end
    end

    // the bit counter restarts whenever the frame ends; no serial edges are needed
    always_ff @(posedge sck or posedge csN) begin
        if (csN) begin
            sh <= '0;
        end else begin
            sh <= next_sh;
        end
    end

    always_ff @(posedge sck or posedge reset) begin
        if (reset) begin
            cap <= '0;
        end else begin
            cap <= next_cap;
        end
    end

    assign opcode     = cap.opcode;
    assign byteToggle = cap.toggle;

endmodule

`default_nettype wire

// ==== tb/spi_host_model.sv ====
/*
 * Host serial controller model: sends one opcode byte per frame, mode 0.
 * Assumes the bench calls sendByte; sck stands still outside frames.
 */
`timescale 1ns/1ns
`default_nettype none

module spi_host_model (
    // link pins
    output logic sck,
    output logic csN,
    output logic mosi
);
    initial begin
        sck  = 1'b0;
        csN  = 1'b1;
        mosi = 1'b1;
    end

    // one frame, msb first, 64 ns serial period
    task automatic sendByte(input logic [7:0] b);
        int i;
        #13;
        csN = 1'b0;
        for (i = 7; i >= 0; i--) begin
            mosi = b[i];
            #32 sck = 1'b1;
            #32 sck = 1'b0;
        end
        #32 csN = 1'b1;
        // released line shows the inverse of the last bit
        mosi = ~mosi;
    endtask
endmodule

`default_nettype wire

// ==== tb/test_flash_suspend_resume_params.sv ====
/*
 * Self-checking bench for the suspend/resume sequencer.
 * Assumes the host model on the link and the bench acting as the engine.
 */
`timescale 1ns/1ns
`default_nettype none

module test_flash_suspend_resume_params;
    localparam logic [7:0] SUSP = flash_susp_pkg::OPC_SUSPEND;
    localparam logic [7:0] RESU = flash_susp_pkg::OPC_RESUME;
    logic clk, reset, sck, csN, mosi;
    logic eraseStart, programStart, engineDone, engineParked;
    logic engineHold, eraseActive, programActive, eraseSuspended, programSuspended;
    logic suspendTooSoon, suspendCapBit;
    int   err_total, check_count, tooSoonCount, n;

    spi_host_model i_host (.sck(sck), .csN(csN), .mosi(mosi));

    flash_suspend_seq i_dut (
        .clk(clk), .reset(reset), .sck(sck), .csN(csN), .mosi(mosi),
        .eraseStart(eraseStart), .programStart(programStart),
        .engineDone(engineDone), .engineParked(engineParked),
        .engineHold(engineHold), .eraseActive(eraseActive),
        .programActive(programActive), .eraseSuspended(eraseSuspended),
        .programSuspended(programSuspended), .suspendTooSoon(suspendTooSoon),
        .suspendCapBit(suspendCapBit)
    );

    always #25 clk = ~clk;

    // sampled mid-cycle so the pulse is settled when it is counted
    always @(negedge clk) begin
        if (suspendTooSoon === 1'b1) tooSoonCount++;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #5;
    endtask

    task automatic sendOp(input logic [7:0] b);
        i_host.sendByte(b);
        tick(6);
    endtask

    function automatic logic [4:0] st();
        return {engineHold, eraseActive, programActive, eraseSuspended, programSuspended};
    endfunction

    // pulses the chosen erase start, program start and done inputs together for one cycle
    task automatic starts(input logic e, input logic p, input logic d);
        eraseStart = e;
        programStart = p;
        engineDone = d;
        tick(1);
        {eraseStart, programStart, engineDone} = 3'h0;
        tick(1);
    endtask

    // sends a suspend and counts cycles from hold to suspended
    task automatic waitSuspend(output int c);
        int w;
        i_host.sendByte(SUSP);
        w = 0;
        while (engineHold !== 1'b1 && w < 20) begin tick(1); w++; end
        c = 0;
        while ((eraseSuspended | programSuspended) !== 1'b1 && c < 600) begin
            tick(1);
            c++;
        end
    endtask

    task automatic test_idle_ignored();
        sendOp(SUSP);
        check(st(), 5'h00);
        sendOp(RESU);
        check(st(), 5'h00);
        check(tooSoonCount, 0);
    endtask

    task automatic test_erase();
        starts(1'b1, 1'b0, 1'b0);
        check(st(), 5'h08);
        sendOp(SUSP);
        check(st(), 5'h10);
        engineParked = 1'b1;
        tick(1);
        engineParked = 1'b0;
        tick(1);
        check(st(), 5'h12);
        // host breaks the prohibition on purpose; starts are dropped
        starts(1'b1, 1'b1, 1'b0);
        check(st(), 5'h12);
        sendOp(RESU);
        check(st(), 5'h08);
        sendOp(SUSP);
        check(st(), 5'h08);
        check(tooSoonCount, 1);
        tick(flash_susp_pkg::RESUME_INT_CYC);
        waitSuspend(n);
        check(n <= flash_susp_pkg::ERASE_SUSP_LAT_CYC, 1'b1);
        check(st(), 5'h12);
        sendOp(RESU);
        starts(1'b0, 1'b0, 1'b1);
        check(st(), 5'h00);
    endtask

    task automatic test_program();
        starts(1'b0, 1'b1, 1'b0);
        check(st(), 5'h04);
        sendOp(8'h3C);
        check(st(), 5'h04);
        waitSuspend(n);
        check(n <= flash_susp_pkg::PROG_SUSP_LAT_CYC, 1'b1);
        check(st(), 5'h11);
        starts(1'b1, 1'b1, 1'b0);
        check(st(), 5'h11);
        sendOp(RESU);
        check(st(), 5'h04);
        sendOp(SUSP);
        check(tooSoonCount, 2);
        check(st(), 5'h04);
        tick(flash_susp_pkg::RESUME_INT_CYC);
        sendOp(SUSP);
        check(st(), 5'h10);
        sendOp(RESU);
        starts(1'b0, 1'b0, 1'b1);
        check(st(), 5'h00);
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #(50 * 20000);
        err_total++;
        end_of_test();
    end

    initial begin
        {clk, eraseStart, programStart, engineDone, engineParked} = 5'h00;
        {err_total, check_count, tooSoonCount} = '0;
        reset = 1'b1;
        tick(3);
        check(st(), 5'h00);
        check(suspendCapBit, flash_susp_pkg::CAP_SUSPEND_SUPPORTED);
        reset = 1'b0;
        tick(1);
        test_idle_ignored();
        test_erase();
        test_program();
        check(suspendCapBit, 1'b0);
        end_of_test();
    end
endmodule

`default_nettype wire
